// ===== design/acf_top.sv
// Purpose: Scheduling, filtering, averaging and error logic of a four-channel converter
// Assumes: Front end delivers a 12-bit code (4000 = full span) valid at each slot end
// Notes:   All state is one struct; AXI4-Lite slave for settings and results
`timescale 1ns/1ps

// Notes on behaviour
// - Only channels marked running are converted; stopped ones are skipped entirely.
// - A full cycle lasts running channel count times 1.5 ms.
// - Without filter or average, each conversion result is stored directly.
// - Filter output is (1-alpha) times new result plus alpha times previous output.
// - Filter constant is per channel, in percent, legal 1 to 99.
// - Filter constant out of range flags error; lamp blinks with 1 s period.
// - Correct setting then stop-to-run clears error and restores steady lamp.
// - Filter disabled means current result is output unchanged.
// - Averaging per channel is time or count, value held per channel.
// - Time average window accepts 4 to 16000 ms.
// - Time samples are window divided by running channels times 1.5 ms, floored.
// - Time window out of range flags error; lamp blinks with 1 s period.
// - Count average accepts 2 to 64000 samples.
// - Count average result appears every count times channels times 1.5 ms.
// - Count out of range flags error; lamp blinks with 1 s period.
// - A bad count setting is replaced and stored as 2.
// - Averaging accumulates results over the window and stores their mean.
// - Four output formats are selectable per channel.
// - Formats: unsigned 0..4047, signed -2000..2047, precise and percentile 0..1011.
// - Values beyond the chosen format range are clamped to its limits.
module acf_top #(
	parameter int unsigned CONV_CYCLES  = acf_pkg::CONV_CYCLES,  // Cycles per conversion slot
	parameter int unsigned BLINK_CYCLES = acf_pkg::BLINK_CYCLES  // Cycles per lamp blink period
) (
	input  wire logic        aclk,                     // Module clock
	input  wire logic        aresetn,                  // Synchronous reset, active low
	input  wire logic        ce,                       // Clock enable, freezes all state
	input  wire logic [7:0]  s_axi_awaddr,             // Write address
	input  wire logic        s_axi_awvalid,            // Write address valid
	output logic             s_axi_awready,            // Write address ready
	input  wire logic [31:0] s_axi_wdata,              // Write data
	input  wire logic [3:0]  s_axi_wstrb,              // Write byte enables
	input  wire logic        s_axi_wvalid,             // Write data valid
	output logic             s_axi_wready,             // Write data ready
	output logic [1:0]       s_axi_bresp,              // Write response
	output logic             s_axi_bvalid,             // Write response valid
	input  wire logic        s_axi_bready,             // Write response ready
	input  wire logic [7:0]  s_axi_araddr,             // Read address
	input  wire logic        s_axi_arvalid,            // Read address valid
	output logic             s_axi_arready,            // Read address ready
	output logic [31:0]      s_axi_rdata,              // Read data
	output logic [1:0]       s_axi_rresp,              // Read response
	output logic             s_axi_rvalid,             // Read data valid
	input  wire logic        s_axi_rready,             // Read data ready
	input  wire logic [11:0] adc_code,                 // Front end conversion code
	output logic [1:0]       adc_sel,                  // Channel being converted
	output logic             adc_take,                 // Pulse: code taken at slot end
	output logic             operating_indicator_lamp  // Steady in run, blinks on error
);

	acf_pkg::acf_state_t q, d;

	// Next running channel after cur, cyclic; returns cur if none other runs
	function automatic logic [1:0] next_ch(input logic [3:0] mask, input logic [1:0] cur);
		logic [1:0] n;
		next_ch = cur;
		for (int i = 4; i >= 1; i--) begin
			n = 2'(cur + 2'(i));
			if (mask[n]) begin
				next_ch = n;
			end
		end
	endfunction

	// Number of running channels
	function automatic logic [2:0] pop4(input logic [3:0] m);
		pop4 = 3'(m[0]) + 3'(m[1]) + 3'(m[2]) + 3'(m[3]);
	endfunction

	// Byte-lane merge for register writes
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		for (int b = 0; b < 4; b++) begin
			merge[b*8 +: 8] = be[b] ? wd[b*8 +: 8] : old[b*8 +: 8];
		end
	endfunction

	// Scale a raw code into the chosen output format with clamping
	function automatic logic signed [15:0] fmt_conv(input logic [11:0] raw, input logic [1:0] f);
		logic signed [15:0] v;
		v = $signed({4'h0, raw});
		fmt_conv = v;
		unique case (f)
			acf_pkg::FMT_UNS: begin
				fmt_conv = (v > acf_pkg::UNS_MAX) ? acf_pkg::UNS_MAX : v;
			end
			acf_pkg::FMT_SGN: begin
				v = v - acf_pkg::SGN_OFS;
				fmt_conv = (v > acf_pkg::SGN_MAX) ? acf_pkg::SGN_MAX :
				           (v < acf_pkg::SGN_MIN) ? acf_pkg::SGN_MIN : v;
			end
			acf_pkg::FMT_PRC, acf_pkg::FMT_PCT: begin
				v = v >>> 2;
				fmt_conv = (v > acf_pkg::PCT_MAX) ? acf_pkg::PCT_MAX : v;
			end
		endcase
	endfunction

	// Config word of one channel as the bus sees it
	function automatic logic [31:0] cfg_word(input acf_pkg::acf_state_t s, input logic [1:0] c);
		cfg_word = '0;
		cfg_word[acf_pkg::CFG_FMT +: 2]   = s.fmt[c];
		cfg_word[acf_pkg::CFG_FILT]       = s.filt_en[c];
		cfg_word[acf_pkg::CFG_AVG]        = s.avg_en[c];
		cfg_word[acf_pkg::CFG_TIME]       = s.avg_time[c];
		cfg_word[acf_pkg::CFG_FC +: 7]    = s.fconst[c];
		cfg_word[acf_pkg::CFG_AVAL +: 16] = s.avg_val[c];
	endfunction

	logic        wr_go;
	logic        rd_go;
	logic [2:0]  nrun;
	logic        bad_now;
	logic        wr_bad;
	logic        clr_req;

	// Joint write accept keeps one write in flight; reads accepted when no data pending
	assign wr_go         = ce & s_axi_awvalid & s_axi_wvalid & ~q.bvalid;
	assign rd_go         = ce & s_axi_arvalid & ~q.rvalid;
	assign s_axi_awready = wr_go;
	assign s_axi_wready  = wr_go;
	assign s_axi_arready = rd_go;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rdata   = q.rdata;
	assign s_axi_rresp   = q.rresp;
	assign adc_sel       = q.cur;
	assign adc_take      = q.strobe;
	assign operating_indicator_lamp = q.lamp;
	assign nrun          = pop4(q.run_mask);

	// Next-state logic for bus, scheduler, channel processing and error lamp
	always_comb begin
		logic [31:0]        w;
		logic [1:0]         c;
		logic signed [15:0] s;
		logic signed [31:0] sum;
		logic signed [31:0] bl;
		logic [31:0]        tgt;
		logic [15:0]        nv;
		w       = '0;
		c       = q.cur;
		s       = '0;
		sum     = '0;
		bl      = '0;
		tgt     = '0;
		nv      = '0;
		wr_bad  = 1'b0;
		clr_req = 1'b0;
		bad_now = 1'b0;
		d        = q;
		d.strobe = 1'b0;

		// Write channel: response held until bready
		if (q.bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		if (wr_go) begin
			d.bvalid = 1'b1;
			d.bresp  = acf_pkg::RESP_OKAY;
			if (s_axi_awaddr[7:2] == acf_pkg::OFS_CTRL[7:2]) begin
				w = merge({7'h0, q.host_run, 4'h0, q.run_mask}, s_axi_wdata, s_axi_wstrb);
				w[31:0] = s_axi_wstrb[2] ? w : {w[31:17], 1'b0, w[15:0]};
				d.run_mask = w[acf_pkg::CTRL_RUN_LSB +: 4];
				d.host_run = w[acf_pkg::CTRL_HOST];
				clr_req    = w[acf_pkg::CTRL_CLR];
			end else if (s_axi_awaddr[7:4] == acf_pkg::OFS_CFG0[7:4]) begin
				c = s_axi_awaddr[3:2];
				w = merge(cfg_word(q, c), s_axi_wdata, s_axi_wstrb);
				d.fmt[c]      = w[acf_pkg::CFG_FMT +: 2];
				d.filt_en[c]  = w[acf_pkg::CFG_FILT];
				d.avg_en[c]   = w[acf_pkg::CFG_AVG];
				d.avg_time[c] = w[acf_pkg::CFG_TIME];
				d.fconst[c]   = w[acf_pkg::CFG_FC +: 7];
				nv = w[acf_pkg::CFG_AVAL +: 16];
				if (w[acf_pkg::CFG_AVG] && !w[acf_pkg::CFG_TIME] &&
				    (nv < acf_pkg::CAVG_MIN || nv > acf_pkg::CAVG_MAX)) begin
					nv     = acf_pkg::CAVG_SUB;
					wr_bad = 1'b1;
				end
				d.avg_val[c] = nv;
				c = q.cur;
			end else if (s_axi_awaddr[7:2] != acf_pkg::OFS_STATUS[7:2] &&
			             s_axi_awaddr[7:4] != acf_pkg::OFS_RES0[7:4]) begin
				d.bresp = acf_pkg::RESP_SLVERR;                                           // Unmapped
			end
		end

		// Read channel: data held until rready
		if (q.rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (rd_go) begin
			d.rvalid = 1'b1;
			d.rresp  = acf_pkg::RESP_OKAY;
			d.rdata  = '0;
			if (s_axi_araddr[7:2] == acf_pkg::OFS_CTRL[7:2]) begin
				d.rdata[acf_pkg::CTRL_RUN_LSB +: 4] = q.run_mask;
				d.rdata[acf_pkg::CTRL_HOST]         = q.host_run;
			end else if (s_axi_araddr[7:2] == acf_pkg::OFS_STATUS[7:2]) begin
				d.rdata[acf_pkg::ST_ERR]        = q.err;
				d.rdata[acf_pkg::ST_LAMP]       = q.lamp;
				d.rdata[acf_pkg::ST_CUR +: 2]   = q.cur;
				d.rdata[acf_pkg::ST_BUSY]       = (q.st == acf_pkg::ST_CONV);
				d.rdata[acf_pkg::ST_VALID +: 4] = q.valid;
			end else if (s_axi_araddr[7:4] == acf_pkg::OFS_CFG0[7:4]) begin
				d.rdata = cfg_word(q, s_axi_araddr[3:2]);
			end else if (s_axi_araddr[7:4] == acf_pkg::OFS_RES0[7:4]) begin
				d.rdata = {{16{q.out[s_axi_araddr[3:2]][15]}}, q.out[s_axi_araddr[3:2]]};
			end else begin
				d.rresp = acf_pkg::RESP_SLVERR;
			end
		end

		// Stopped channels drop partial averages so a restart begins a fresh window
		for (int i = 0; i < 4; i++) begin
			if (!q.run_mask[i]) begin
				d.acc[i]   = '0;
				d.cnt[i]   = '0;
				d.valid[i] = 1'b0;
			end
		end

		// Slot scheduler: one slot of CONV_CYCLES per running channel
		unique case (q.st)
			acf_pkg::ST_IDLE: begin
				d.slot = '0;
				if (q.run_mask != 4'h0) begin
					d.st  = acf_pkg::ST_CONV;
					d.cur = next_ch(q.run_mask, 2'h3);
				end
			end
			acf_pkg::ST_CONV: begin
				if (q.slot != 32'(CONV_CYCLES - 1)) begin
					d.slot = q.slot + 32'h1;
				end else begin
					d.slot   = '0;
					d.strobe = 1'b1;
					d.cur    = next_ch(q.run_mask, q.cur);
					if (q.run_mask == 4'h0) begin
						d.st = acf_pkg::ST_IDLE;
					end
					if (q.run_mask[c]) begin
						s = fmt_conv(adc_code, q.fmt[c]);
						if (q.avg_en[c]) begin
							if (q.avg_time[c]) begin
								tgt = (32'(q.avg_val[c]) * 32'd1000) /
								      (32'(nrun) * acf_pkg::CONV_TIME_US);
							end else begin
								tgt = 32'(q.avg_val[c]);
							end
							if (tgt == 32'h0) begin
								tgt = 32'h1;
							end
							sum = q.acc[c] + 32'(s);
							if (32'(q.cnt[c]) + 32'h1 >= tgt) begin
								d.out[c]   = 16'(sum / $signed(tgt));
								d.acc[c]   = '0;
								d.cnt[c]   = '0;
								d.valid[c] = 1'b1;
							end else begin
								d.acc[c] = sum;
								d.cnt[c] = q.cnt[c] + 16'h1;
							end
						end else if (q.filt_en[c]) begin
							bl = 32'(7'd100 - q.fconst[c]) * 32'(s) +
							     $signed({25'h0, q.fconst[c]}) * 32'($signed(q.out[c]));
							bl = (bl >= 0) ? (bl + 32'sd50) / 32'sd100 :
							                 (bl - 32'sd50) / 32'sd100;
							d.out[c]   = 16'(bl);
							d.valid[c] = 1'b1;
						end else begin
							d.out[c]   = s;
							d.valid[c] = 1'b1;
						end
					end
				end
			end
			default: begin
				d.st = acf_pkg::ST_IDLE;
			end
		endcase

		// Range checks on every channel whose option is switched on
		for (int i = 0; i < 4; i++) begin
			if (q.filt_en[i] && (q.fconst[i] < acf_pkg::FC_MIN ||
			    q.fconst[i] > acf_pkg::FC_MAX)) begin
				bad_now = 1'b1;
			end
			if (q.avg_en[i] && q.avg_time[i] && (q.avg_val[i] < acf_pkg::TAVG_MIN ||
			    q.avg_val[i] > acf_pkg::TAVG_MAX)) begin
				bad_now = 1'b1;
			end
		end

		// Error is sticky; a fresh fault wins over clear request or stop-to-run
		d.run_prev = q.host_run;
		if (clr_req || (q.host_run && !q.run_prev)) begin
			d.err = 1'b0;
		end
		if (bad_now || wr_bad) begin
			d.err = 1'b1;
		end

		// Blink timer toggles the phase every half period
		if (q.blink >= 32'(BLINK_CYCLES / 2 - 1)) begin
			d.blink = '0;
			d.phase = ~q.phase;
		end else begin
			d.blink = q.blink + 32'h1;
		end
		d.lamp = q.host_run & (~q.err | q.phase);
	end

	// State register; clock enable freezes everything including the bus
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q         <= '0;
			q.st      <= acf_pkg::ST_IDLE;
			q.fconst  <= {4{acf_pkg::FC_RST}};
			q.avg_val <= {4{acf_pkg::AVAL_RST}};
		end else if (ce) begin
			q <= d;
		end
	end

endmodule

// ===== design/acf_pkg.sv
// Purpose: Shared constants and types for the four-channel converter post-processing block
// Assumes: 20 MHz module clock, 32-bit AXI4-Lite register access
// Notes:   Offsets are byte addresses; each register takes one aligned word
package acf_pkg;
	// Timing
	localparam int unsigned CLK_PERIOD_NS = 50;
	localparam int unsigned CONV_TIME_US  = 1500;       // Per-channel conversion time 1.5 ms
	localparam int unsigned CONV_CYCLES   = CONV_TIME_US * 1000 / CLK_PERIOD_NS;
	localparam int unsigned BLINK_TIME_MS = 1000;       // Lamp blink period 1 s
	localparam int unsigned BLINK_CYCLES  = BLINK_TIME_MS * 1000 * (1000 / CLK_PERIOD_NS);

	// Register byte offsets
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_CFG0   = 8'h10;          // Channel n config at OFS_CFG0 + 4n
	localparam logic [7:0] OFS_RES0   = 8'h20;          // Channel n result at OFS_RES0 + 4n

	// Control register fields
	localparam int CTRL_RUN_LSB = 0;                    // Channel run mask [3:0]
	localparam int CTRL_HOST    = 8;                    // Host in run state
	localparam int CTRL_CLR     = 16;                   // Error clear request, write one

	// Status register fields
	localparam int ST_ERR   = 0;
	localparam int ST_LAMP  = 1;
	localparam int ST_CUR   = 4;
	localparam int ST_BUSY  = 8;
	localparam int ST_VALID = 16;

	// Channel config fields
	localparam int CFG_FMT   = 0;                       // [1:0] output format
	localparam int CFG_FILT  = 2;
	localparam int CFG_AVG   = 3;
	localparam int CFG_TIME  = 4;                       // 1 time average, 0 count average
	localparam int CFG_FC    = 8;                       // [14:8] filter constant in percent
	localparam int CFG_AVAL  = 16;                      // [31:16] average time or count

	// Reset values and legal ranges
	localparam logic [6:0]  FC_RST   = 7'h01;
	localparam logic [15:0] AVAL_RST = 16'h0002;
	localparam logic [6:0]  FC_MIN   = 7'h01;
	localparam logic [6:0]  FC_MAX   = 7'h63;           // 99
	localparam logic [15:0] TAVG_MIN = 16'h0004;
	localparam logic [15:0] TAVG_MAX = 16'h3e80;        // 16000 ms
	localparam logic [15:0] CAVG_MIN = 16'h0002;
	localparam logic [15:0] CAVG_MAX = 16'hfa00;        // 64000
	localparam logic [15:0] CAVG_SUB = 16'h0002;        // Substitute for a bad count

	// Output format codes and clamp limits
	localparam logic [1:0]  FMT_UNS  = 2'h0;
	localparam logic [1:0]  FMT_SGN  = 2'h1;
	localparam logic [1:0]  FMT_PRC  = 2'h2;
	localparam logic [1:0]  FMT_PCT  = 2'h3;
	localparam logic signed [15:0] UNS_MAX = 16'sh0fcf; // 4047
	localparam logic signed [15:0] SGN_OFS = 16'sh07d0; // 2000
	localparam logic signed [15:0] SGN_MIN = -16'sh07d0;
	localparam logic signed [15:0] SGN_MAX = 16'sh07ff; // 2047
	localparam logic signed [15:0] PCT_MAX = 16'sh03f3; // 1011

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_CONV = 2'b10
	} acf_sched_t;

	typedef struct packed {
		logic                   bvalid;
		logic [1:0]             bresp;
		logic                   rvalid;
		logic [31:0]            rdata;
		logic [1:0]             rresp;
		logic [3:0]             run_mask;
		logic                   host_run;
		logic                   run_prev;
		logic [3:0][1:0]        fmt;
		logic [3:0]             filt_en;
		logic [3:0]             avg_en;
		logic [3:0]             avg_time;
		logic [3:0][6:0]        fconst;
		logic [3:0][15:0]       avg_val;
		acf_sched_t             st;
		logic [1:0]             cur;
		logic [31:0]            slot;
		logic                   strobe;
		logic [3:0][15:0]       out;
		logic [3:0][31:0]       acc;
		logic [3:0][15:0]       cnt;
		logic [3:0]             valid;
		logic                   err;
		logic [31:0]            blink;
		logic                   phase;
		logic                   lamp;
	} acf_state_t;
endpackage

// ===== sim/acf_chk_sva.sv
// Purpose: Port-level assertions for the converter post-processing block
// Assumes: Clock enable held high; one clock domain
// Notes:   Bound to acf_top from the bench top file
`timescale 1ns/1ps
module acf_chk #(
	parameter int unsigned CONV_CYCLES = 20  // Cycles per conversion slot
) (
	input wire logic        aclk,                     // Module clock
	input wire logic        aresetn,                  // Reset, active low
	input wire logic [7:0]  s_axi_awaddr,             // Write address
	input wire logic        s_axi_awvalid,            // Write address valid
	input wire logic        s_axi_awready,            // Write address ready
	input wire logic        s_axi_wvalid,             // Write data valid
	input wire logic        s_axi_wready,             // Write data ready
	input wire logic [1:0]  s_axi_bresp,              // Write response
	input wire logic        s_axi_bvalid,             // Write response valid
	input wire logic        s_axi_bready,             // Write response ready
	input wire logic [7:0]  s_axi_araddr,             // Read address
	input wire logic        s_axi_arready,            // Read address ready
	input wire logic [31:0] s_axi_rdata,              // Read data
	input wire logic [1:0]  s_axi_rresp,              // Read response
	input wire logic        s_axi_rvalid,             // Read data valid
	input wire logic        s_axi_rready,             // Read data ready
	input wire logic        adc_take,                 // Code taken pulse
	input wire logic        operating_indicator_lamp  // Run lamp
);
	logic [31:0] gap_q;
	logic        seen_q;

	// Cycles since the last take; a control write may restart the schedule, so forget it
	always_ff @(posedge aclk) begin
		if (!aresetn || (s_axi_awready && s_axi_awaddr == acf_pkg::OFS_CTRL)) begin
			seen_q <= 1'b0;
			gap_q  <= 32'h0;
		end else begin
			seen_q <= seen_q | adc_take;
			gap_q  <= adc_take ? 32'h1 : gap_q + 32'h1;
		end
	end

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// Bus handshakes and responses
	wr_pair_a: assert property (s_axi_awready |-> s_axi_wready && s_axi_awvalid && s_axi_wvalid)
		else $error("write address and data not taken together");
	wr_resp_a: assert property (s_axi_awready |=> s_axi_bvalid)
		else $error("write response not one cycle after taking");
	wr_order_a: assert property (s_axi_bvalid |-> !s_axi_awready)
		else $error("write taken while response pending");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before ready");
	rd_resp_a: assert property (s_axi_arready |=> s_axi_rvalid)
		else $error("read data not one cycle after taking");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data changed before ready");
	unmap_rd_a: assert property (s_axi_arready && s_axi_araddr >= 8'h30 |=>
		s_axi_rresp == acf_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read not refused");
	// Take is a single-cycle pulse, one per slot
	take_pulse_a: assert property (adc_take |=> !adc_take)
		else $error("take pulse longer than one cycle");
	slot_len_a: assert property (
		adc_take && seen_q |-> gap_q == CONV_CYCLES)
		else $error("slot length wrong");

	cover property (adc_take && seen_q);
	cover property (s_axi_arready && s_axi_araddr >= 8'h30);
	cover property ($rose(operating_indicator_lamp));
endmodule

// ===== sim/acf_fe_model.sv
// Purpose: Front end model handing each channel's code to the block
// Assumes: The selected channel's code is ready for the whole slot
// Notes:   Levels per channel are set by the bench
`timescale 1ns/1ps
module acf_fe_model (
	input  wire logic [1:0]       adc_sel,  // Channel being converted
	input  wire logic [3:0][11:0] level,    // Input level per channel
	output logic      [11:0]      adc_code  // Code of the selected channel
);
	// A plain mux: the converter answers with the selected channel's level
	assign adc_code = level[adc_sel];
endmodule

// ===== sim/tb.sv
// Purpose: Self-checking bench for the converter post-processing block
// Assumes: Short slot and blink counts; channels 0 and 2 run, 1 holds bad settings
// Notes:   Config word: [31:16] value, [14:8] constant, [4] time, [3] avg, [2] filt, [1:0] fmt
`timescale 1ns/1ps
bind acf_top acf_chk #(.CONV_CYCLES(CONV_CYCLES)) acf_chk_inst (.aclk(aclk),
	.aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
	.adc_take(adc_take), .operating_indicator_lamp(operating_indicator_lamp));
module tb;
	localparam int unsigned CC = 20;
	localparam int unsigned BC = 16;
	localparam logic [7:0] CTL = acf_pkg::OFS_CTRL;
	localparam logic [7:0] ST = acf_pkg::OFS_STATUS;
	localparam logic [7:0] CFG = acf_pkg::OFS_CFG0;
	localparam logic [7:0] RES = acf_pkg::OFS_RES0;
	localparam logic [31:0] BAD [6] = '{32'h0002_0004, 32'h0002_6404, 32'h0003_0118,
		32'h3e81_0118, 32'h0001_0108, 32'hfa01_0108};
	localparam logic [31:0] GOOD [5] = '{32'h0002_6304, 32'h3e80_0118, 32'h0004_0118,
		32'hfa00_0108, 32'h0002_0108};
	localparam logic [11:0] CD [3] = '{12'd4095, 12'd2000, 12'd0};
	localparam logic [31:0] AC [2] = '{32'h0002_0108, 32'h0008_0118};
	localparam logic [31:0] AL [2] = '{32'd1000, 32'd400};
	localparam logic [31:0] AB [2] = '{32'd3000, 32'd800};
	localparam logic [31:0] AP [2] = '{32'd2047, 32'd2000};
	logic             aclk = 1'b0;
	logic             aresetn = 1'b0;
	logic [7:0]       awaddr = 8'h00;
	logic [7:0]       araddr = 8'h00;
	logic [31:0]      wdata = 32'h0;
	logic             awvalid = 1'b0;
	logic             wvalid = 1'b0;
	logic             bready = 1'b0;
	logic             arvalid = 1'b0;
	logic             rready = 1'b0;
	logic [3:0][11:0] level = '0;
	logic             awready, wready, bvalid, arready, rvalid, take, lamp;
	logic [1:0]       bresp, rresp, sel, br, rs;
	logic [31:0]      rdata, rd;
	logic [11:0]      code;
	int               error_cnt = 0;
	int               comparisons = 0;
	int               cyc = 0;

	acf_top #(.CONV_CYCLES(CC), .BLINK_CYCLES(BC)) acf_top_inst (.aclk(aclk), .aresetn(aresetn),
		.ce(1'b1), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.adc_code(code), .adc_sel(sel), .adc_take(take), .operating_indicator_lamp(lamp));
	acf_fe_model acf_fe_model_inst (.adc_sel(sel), .level(level), .adc_code(code));

	// Clock and hang guard; the whole run needs well under two thousand cycles
	always #25 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			error_cnt++;
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		if (error_cnt == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Ready is raised a cycle late so the response must hold
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do @(posedge aclk); while (awready !== 1'b1 && ++n < 100);
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		@(posedge aclk);
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1 && ++n < 100);
		bready <= 1'b0;
		br = bresp;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1 && ++n < 100);
		arvalid <= 1'b0;
		@(posedge aclk);
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1 && ++n < 100);
		rready <= 1'b0;
		rd = rdata;
		rs = rresp;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		rd_reg(a);
		chk(rd & m, e);
	endtask

	// Returns at the edge where the take for channel c is seen
	task automatic conv(input logic [1:0] c);
		logic [1:0] p;
		int         n;
		n = 0;
		do begin
			p = sel;
			@(posedge aclk);
		end while (!(take === 1'b1 && p === c) && ++n < 2000);
	endtask

	// Touch a channel right after the other one converts, so no conversion is missed
	task automatic sw(input logic [1:0] tg, input logic [31:0] d, input logic [11:0] lvl);
		conv(tg ^ 2'h2);
		level[tg] <= lvl;
		wr(CFG + 8'(4 * tg), d);
		conv(tg);
	endtask

	task automatic lamp_chk(input int n);
		int k;
		k = 0;
		repeat (2 * BC) begin
			@(posedge aclk);
			k += (lamp === 1'b1);
		end
		chk(32'(k), 32'(n));
	endtask

	function automatic logic [31:0] fmt(input logic [1:0] f, input logic [11:0] c);
		int v;
		case (f)
			acf_pkg::FMT_UNS: v = (c > 4047) ? 4047 : int'(c);
			acf_pkg::FMT_SGN: v = (c > 4047) ? 2047 : int'(c) - 2000;
			default: v = (c > 4047) ? 1011 : int'(c) / 4;
		endcase
		return 32'(v);
	endfunction

	task automatic t_reset();
		rchk(CFG + 8'h4, '1, 32'h0002_0100);
		rchk(CTL, '1, 32'h0);
		rchk(8'h40, '1, 32'h0);
		chk(32'(rs), 32'(acf_pkg::RESP_SLVERR));
		wr(8'h40, 32'h1);
		chk(32'(br), 32'(acf_pkg::RESP_SLVERR));
	endtask

	task automatic t_sample();
		level[0] <= 12'd1000;
		level[2] <= 12'd4095;
		wr(CFG + 8'h8, 32'h0002_0101);
		wr(CTL, 32'h0000_0105);
		repeat (2) begin
			conv(0);
			chk(32'(sel), 32'h2);
			conv(2);
			chk(32'(sel), 32'h0);
		end
		rchk(RES, '1, 32'd1000);
		rchk(RES + 8'h4, '1, 32'h0);
		rchk(RES + 8'h8, '1, 32'd2047);
	endtask

	task automatic t_filter();
		sw(0, 32'h0002_0100, 12'd1000);
		sw(0, 32'h0002_3204, 12'd4000);
		rchk(RES, '1, 32'd2500);
		conv(0);
		rchk(RES, '1, 32'd3250);
		sw(0, 32'h0002_6304, 12'd4000);
		rchk(RES, '1, 32'd3258);
		sw(0, 32'h0002_6300, 12'd4000);
		rchk(RES, '1, 32'd4000);
		for (int f = 0; f < 4; f++)
			for (int i = 0; i < 3; i++) begin
				sw(0, 32'h0002_0100 | 32'(f), CD[i]);
				rchk(RES, '1, fmt(2'(f), CD[i]));
			end
	endtask

	// Stopping channel 2 clears its partial window, so the window start is known
	task automatic t_avg();
		for (int m = 0; m < 2; m++) begin
			wr(CTL, 32'h0000_0101);
			level[2] <= 12'(AL[m]);
			wr(CFG + 8'h8, AC[m]);
			wr(CTL, 32'h0000_0105);
			conv(2);
			rchk(RES + 8'h8, '1, AP[m]);
			level[2] <= 12'(AB[m]);
			conv(2);
			rchk(RES + 8'h8, '1, (AL[m] + AB[m]) / 2);
		end
	endtask

	task automatic t_err();
		for (int i = 0; i < 6; i++) begin
			wr(CFG + 8'h4, BAD[i]);
			rchk(ST, 32'h1, 32'h1);
			if (i > 3)
				rchk(CFG + 8'h4, 32'hffff_0000, 32'h0002_0000);
			if (i == 0)
				lamp_chk(BC);
			wr(CFG + 8'h4, 32'h0002_0100);
			rchk(ST, 32'h1, 32'h1);
			wr(CTL, 32'h0001_0105);
			rchk(ST, 32'h1, 32'h0);
		end
		foreach (GOOD[i]) begin
			wr(CFG + 8'h4, GOOD[i]);
			rchk(ST, 32'h1, 32'h0);
		end
		wr(CFG + 8'h4, BAD[0]);
		wr(CFG + 8'h4, 32'h0002_0100);
		wr(CTL, 32'h0000_0005);
		rchk(ST, 32'h3, 32'h1);
		wr(CTL, 32'h0000_0105);
		rchk(ST, 32'h3, 32'h2);
		lamp_chk(2 * BC);
	endtask

	// Main sequence
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset();
		t_sample();
		t_filter();
		t_avg();
		t_err();
		report_and_stop();
	end
endmodule
